// ===== core/ttc_top.sv
// Triple timer/counter unit with APB register access
`timescale 1ns/10ps
module ttc_top
	import ttc_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RSTN,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Count inputs
	input  wire logic        ZERO_TIMER_COUNT_PIN,
	input  wire logic        FIRST_TIMER_COUNT_PIN,
	input  wire logic        THIRD_TIMER_EVENT_PIN,
	input  wire logic        LOW_FREQ_CLOCK,
	// Service entry acknowledge, one-cycle pulses
	input  wire logic        ZERO_TIMER_SERVICE,
	input  wire logic        FIRST_TIMER_SERVICE,
	// Flags and overflow pulses
	output logic             ZERO_TIMER_OVERFLOW_FLAG,
	output logic             FIRST_TIMER_OVERFLOW_FLAG,
	output logic             FIRST_TIMER_OVERFLOW,
	output logic             THIRD_TIMER_OVERFLOW
);
	ttc_edge_if e0 ();
	ttc_edge_if e1 ();
	ttc_edge_if e2 ();
	ttc_edge_if ex ();

	logic [7:0]  timer_control_status_ff;
	logic [7:0]  timer_mode_config_ff;
	logic [7:0]  zero_timer_low_byte_ff, zero_timer_high_byte_ff;
	logic [7:0]  first_timer_low_byte_ff, first_timer_high_byte_ff;
	logic [15:0] third_timer_ff;
	logic [7:0]  third_timer_control_ff;
	logic [15:0] reload_ff;
	logic [15:0] cap_ff [TTC_CAP_NUM];
	logic [3:0]  pre12_ff;
	logic [4:0]  pre2_ff;
	logic        lf_prev_ff, trig_ff;
	logic [31:0] PRDATA_ff;
	logic        PREADY_ff, PSLVERR_ff;
	logic        ovf1_ff, ovf2_ff;

	// Count pins through the shared detector
	assign e0.pin = ZERO_TIMER_COUNT_PIN;
	assign e1.pin = FIRST_TIMER_COUNT_PIN;
	assign e2.pin = THIRD_TIMER_EVENT_PIN;
	assign ex.pin = trig_ff;
	ttc_fall_det u_fd0 (.CLK(CLK), .RSTN(RSTN), .edge_io(e0.det));
	ttc_fall_det u_fd1 (.CLK(CLK), .RSTN(RSTN), .edge_io(e1.det));
	ttc_fall_det u_fd2 (.CLK(CLK), .RSTN(RSTN), .edge_io(e2.det));
	ttc_fall_det u_fdx (.CLK(CLK), .RSTN(RSTN), .edge_io(ex.det));

	// APB decode; zero wait states, write at the access edge
	logic wr_en, rd_en, hit;
	assign wr_en = PSEL & PENABLE & PWRITE;
	assign rd_en = PSEL & ~PENABLE & ~PWRITE;
	assign hit = (PADDR <= TTC_ACK_OFF) && (PADDR[1:0] == 2'b00);
	logic w_ctrl, w_mode, w_tm0, w_tm1, w_t2c, w_tm2, w_rld, w_cap;
	assign w_ctrl = wr_en && PADDR == TTC_CTRL_OFF;
	assign w_mode = wr_en && PADDR == TTC_MODE_OFF;
	assign w_tm0  = wr_en && PADDR == TTC_TM0_OFF;
	assign w_tm1  = wr_en && PADDR == TTC_TM1_OFF;
	assign w_t2c  = wr_en && PADDR == TTC_T2CTL_OFF;
	assign w_tm2  = wr_en && PADDR == TTC_TM2_OFF;
	assign w_rld  = wr_en && PADDR == TTC_RLD_OFF;
	// Software capture strobe: write to offset ACK with index in data
	assign w_cap  = wr_en && PADDR == TTC_ACK_OFF;

	// Field aliases
	logic       run0, run1, ct0, ct1;
	logic [1:0] mode0, mode1, in_sel, rl_mode;
	assign run0   = timer_control_status_ff[TTC_RN0_BIT];
	assign run1   = timer_control_status_ff[TTC_RN1_BIT];
	assign mode0  = timer_mode_config_ff[1:0];
	assign ct0    = timer_mode_config_ff[2];
	assign mode1  = timer_mode_config_ff[5:4];
	assign ct1    = timer_mode_config_ff[6];
	assign in_sel = third_timer_control_ff[1:0];
	assign rl_mode = third_timer_control_ff[4:3];

	// Shared 12-cycle tick and 24-cycle tick
	logic tick12, tick24;
	assign tick12 = (pre12_ff == 4'(TTC_PRE_LAST12));
	assign tick24 = (pre2_ff == TTC_PRE_LAST24);
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pre12_ff <= 4'h0;
			pre2_ff  <= 5'h00;
		end else begin
			pre12_ff <= tick12 ? 4'h0 : pre12_ff + 4'h1;
			pre2_ff  <= tick24 ? 5'h00 : pre2_ff + 5'h01;
		end
	end

	// Reload trigger: internal half-rate copy of the low-frequency clock
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			lf_prev_ff <= 1'b0;
			trig_ff    <= 1'b0;
		end else begin
			lf_prev_ff <= LOW_FREQ_CLOCK;
			if (LOW_FREQ_CLOCK & ~lf_prev_ff)
				trig_ff <= ~trig_ff;
		end
	end

	// Count enables
	logic inc0, inc1, inc0h;
	assign inc0  = run0 & (ct0 ? e0.fall : tick12);
	assign inc1  = run1 & (ct1 ? e1.fall : tick12);
	// Split mode: upper half of timer zero is a timer on timer one's run
	assign inc0h = run1 & tick12;

	// Timer zero
	logic [7:0] nxt_t0l, nxt_t0h;
	logic       ovf0, ovf1;
	always_comb begin
		nxt_t0l = zero_timer_low_byte_ff;
		nxt_t0h = zero_timer_high_byte_ff;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		case (mode0)
			TTC_M13: if (inc0) begin
				nxt_t0l[4:0] = zero_timer_low_byte_ff[4:0] + 5'h01;
				if (&zero_timer_low_byte_ff[4:0]) begin
					nxt_t0h = zero_timer_high_byte_ff + 8'h01;
					ovf0 = &zero_timer_high_byte_ff;
				end
			end
			TTC_M16: if (inc0) begin
				{nxt_t0h, nxt_t0l} = {zero_timer_high_byte_ff,
					zero_timer_low_byte_ff} + 16'h0001;
				ovf0 = &{zero_timer_high_byte_ff, zero_timer_low_byte_ff};
			end
			TTC_M8R: if (inc0) begin
				if (&zero_timer_low_byte_ff) begin
					nxt_t0l = zero_timer_high_byte_ff;
					ovf0 = 1'b1;
				end else begin
					nxt_t0l = zero_timer_low_byte_ff + 8'h01;
				end
			end
			TTC_MSPL: begin
				if (inc0) begin
					nxt_t0l = zero_timer_low_byte_ff + 8'h01;
					ovf0 = &zero_timer_low_byte_ff;
				end
				// Upper half raises timer one's flag instead
				if (inc0h) begin
					nxt_t0h = zero_timer_high_byte_ff + 8'h01;
					ovf1 = &zero_timer_high_byte_ff;
				end
			end
			default: ;
		endcase
	end

	// Timer one
	logic [7:0] nxt_t1l, nxt_t1h;
	logic       wrap1;
	always_comb begin
		nxt_t1l = first_timer_low_byte_ff;
		nxt_t1h = first_timer_high_byte_ff;
		wrap1 = 1'b0;
		if (inc1) begin
			case (mode1)
				TTC_M13: begin
					nxt_t1l[4:0] = first_timer_low_byte_ff[4:0] + 5'h01;
					if (&first_timer_low_byte_ff[4:0]) begin
						nxt_t1h = first_timer_high_byte_ff + 8'h01;
						wrap1 = &first_timer_high_byte_ff;
					end
				end
				TTC_M16: begin
					{nxt_t1h, nxt_t1l} = {first_timer_high_byte_ff,
						first_timer_low_byte_ff} + 16'h0001;
					wrap1 = &{first_timer_high_byte_ff,
						first_timer_low_byte_ff};
				end
				TTC_M8R: begin
					wrap1 = &first_timer_low_byte_ff;
					nxt_t1l = wrap1 ? first_timer_high_byte_ff
						: first_timer_low_byte_ff + 8'h01;
				end
				TTC_MSPL: ;
				default: ;
			endcase
		end
	end

	// Flags only from timer one when timer zero is not split
	logic set_tf1;
	assign set_tf1 = (mode0 == TTC_MSPL) ? ovf1 : wrap1;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			zero_timer_low_byte_ff   <= TTC_BYTE_RST;
			zero_timer_high_byte_ff  <= TTC_BYTE_RST;
			first_timer_low_byte_ff  <= TTC_BYTE_RST;
			first_timer_high_byte_ff <= TTC_BYTE_RST;
		end else begin
			zero_timer_low_byte_ff   <= w_tm0 ? PWDATA[7:0] : nxt_t0l;
			zero_timer_high_byte_ff  <= w_tm0 ? PWDATA[15:8] : nxt_t0h;
			first_timer_low_byte_ff  <= w_tm1 ? PWDATA[7:0] : nxt_t1l;
			first_timer_high_byte_ff <= w_tm1 ? PWDATA[15:8] : nxt_t1h;
		end
	end

	// Control/status; hardware set wins over clear
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			timer_control_status_ff <= TTC_BYTE_RST;
		end else begin
			if (w_ctrl)
				timer_control_status_ff <= PWDATA[7:0];
			if (ZERO_TIMER_SERVICE)
				timer_control_status_ff[TTC_OV0_BIT] <= 1'b0;
			if (FIRST_TIMER_SERVICE)
				timer_control_status_ff[TTC_OV1_BIT] <= 1'b0;
			if (ovf0)
				timer_control_status_ff[TTC_OV0_BIT] <= 1'b1;
			if (set_tf1)
				timer_control_status_ff[TTC_OV1_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			timer_mode_config_ff   <= TTC_BYTE_RST;
			third_timer_control_ff <= TTC_BYTE_RST;
			reload_ff              <= TTC_WORD_RST;
		end else begin
			if (w_mode)
				timer_mode_config_ff <= PWDATA[7:0];
			if (w_t2c)
				third_timer_control_ff <= PWDATA[7:0];
			if (w_rld)
				reload_ff <= PWDATA[15:0];
		end
	end

	// Timer two
	logic pre_tick, inc2, wrap2;
	assign pre_tick = third_timer_control_ff[7] ? tick24 : tick12;
	always_comb begin
		case (in_sel)
			TTC_IS_STOP:  inc2 = 1'b0;
			TTC_IS_CLK:   inc2 = pre_tick;
			TTC_IS_EVT:   inc2 = e2.fall;
			TTC_IS_GATED: inc2 = pre_tick & THIRD_TIMER_EVENT_PIN;
			default:      inc2 = 1'b0;
		endcase
	end
	assign wrap2 = inc2 & (&third_timer_ff);

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			third_timer_ff <= TTC_WORD_RST;
		end else if (w_tm2) begin
			third_timer_ff <= PWDATA[15:0];
		end else if (rl_mode == TTC_RL_TRIG && ex.fall) begin
			third_timer_ff <= reload_ff;
		end else if (wrap2 && rl_mode == TTC_RL_OVF) begin
			third_timer_ff <= reload_ff;
		end else if (inc2) begin
			third_timer_ff <= third_timer_ff + 16'h0001;
		end
	end

	// Captures copy the live count without pausing it
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < TTC_CAP_NUM; i++)
				cap_ff[i] <= TTC_WORD_RST;
		end else if (w_cap) begin
			cap_ff[PWDATA[1:0]] <= third_timer_ff;
		end
	end

	// Overflow pulses
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ovf1_ff <= 1'b0;
			ovf2_ff <= 1'b0;
		end else begin
			ovf1_ff <= wrap1;
			ovf2_ff <= wrap2;
		end
	end

	// Read data captured in setup, answered in access
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (PADDR)
			TTC_CTRL_OFF:  rd_mux[7:0] = timer_control_status_ff;
			TTC_MODE_OFF:  rd_mux[7:0] = timer_mode_config_ff;
			TTC_TM0_OFF:   rd_mux[15:0] = {zero_timer_high_byte_ff,
				zero_timer_low_byte_ff};
			TTC_TM1_OFF:   rd_mux[15:0] = {first_timer_high_byte_ff,
				first_timer_low_byte_ff};
			TTC_T2CTL_OFF: rd_mux[7:0] = third_timer_control_ff;
			TTC_TM2_OFF:   rd_mux[15:0] = third_timer_ff;
			TTC_RLD_OFF:   rd_mux[15:0] = reload_ff;
			TTC_CAP_OFF:   rd_mux[15:0] = cap_ff[0];
			TTC_CAP_OFF + 8'h04: rd_mux[15:0] = cap_ff[1];
			TTC_CAP_OFF + 8'h08: rd_mux[15:0] = cap_ff[2];
			TTC_CAP_OFF + 8'h0C: rd_mux[15:0] = cap_ff[3];
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			PRDATA_ff  <= 32'h0000_0000;
			PREADY_ff  <= 1'b0;
			PSLVERR_ff <= 1'b0;
		end else begin
			PREADY_ff  <= PSEL & ~PENABLE;
			PSLVERR_ff <= PSEL & ~PENABLE & ~hit;
			if (rd_en)
				PRDATA_ff <= rd_mux;
		end
	end

	assign PRDATA  = PRDATA_ff;
	assign PREADY  = PREADY_ff;
	assign PSLVERR = PSLVERR_ff;
	assign ZERO_TIMER_OVERFLOW_FLAG  = timer_control_status_ff[TTC_OV0_BIT];
	assign FIRST_TIMER_OVERFLOW_FLAG = timer_control_status_ff[TTC_OV1_BIT];
	assign FIRST_TIMER_OVERFLOW      = ovf1_ff;
	assign THIRD_TIMER_OVERFLOW      = ovf2_ff;
endmodule

// ===== core/ttc_pkg.sv
// Package for the triple timer/counter unit: offsets, fields, counts
package ttc_pkg;
	// APB register byte offsets
	localparam logic [7:0] TTC_CTRL_OFF   = 8'h00;
	localparam logic [7:0] TTC_MODE_OFF   = 8'h04;
	localparam logic [7:0] TTC_TM0_OFF    = 8'h08;
	localparam logic [7:0] TTC_TM1_OFF    = 8'h0C;
	localparam logic [7:0] TTC_T2CTL_OFF  = 8'h10;
	localparam logic [7:0] TTC_TM2_OFF    = 8'h14;
	localparam logic [7:0] TTC_RLD_OFF    = 8'h18;
	localparam logic [7:0] TTC_CAP_OFF    = 8'h1C;
	localparam logic [7:0] TTC_ACK_OFF    = 8'h2C;
	localparam int         TTC_CAP_NUM    = 4;
	// Control/status field positions
	localparam int TTC_OV1_BIT = 7;
	localparam int TTC_RN1_BIT = 6;
	localparam int TTC_OV0_BIT = 5;
	localparam int TTC_RN0_BIT = 4;
	// Reset values
	localparam logic [7:0]  TTC_BYTE_RST = 8'h00;
	localparam logic [15:0] TTC_WORD_RST = 16'h0000;
	// Mode and input-select codes
	localparam logic [1:0] TTC_M13  = 2'b00;
	localparam logic [1:0] TTC_M16  = 2'b01;
	localparam logic [1:0] TTC_M8R  = 2'b10;
	localparam logic [1:0] TTC_MSPL = 2'b11;
	localparam logic [1:0] TTC_IS_STOP  = 2'b00;
	localparam logic [1:0] TTC_IS_CLK   = 2'b01;
	localparam logic [1:0] TTC_IS_EVT   = 2'b10;
	localparam logic [1:0] TTC_IS_GATED = 2'b11;
	localparam logic [1:0] TTC_RL_OVF  = 2'b10;
	localparam logic [1:0] TTC_RL_TRIG = 2'b11;
	// Prescale counts in core cycles
	localparam int TTC_PRE12 = 12;
	localparam int TTC_PRE24 = 24;
	localparam logic [4:0] TTC_PRE_LAST12 = 5'(TTC_PRE12 - 1);
	localparam logic [4:0] TTC_PRE_LAST24 = 5'(TTC_PRE24 - 1);
endpackage

// ===== core/ttc_edge_if.sv
// Interface carrying a sampled pin and its falling-edge pulse
`timescale 1ns/10ps
interface ttc_edge_if;
	logic pin;
	logic fall;
	modport det (input pin, output fall);
	modport use_side (output pin, input fall);
endinterface

// ===== core/ttc_fall_det.sv
// Falling-edge detector for a synchronous count input
`timescale 1ns/10ps
module ttc_fall_det (
	// Clock and reset
	input wire logic CLK,
	input wire logic RSTN,
	// Pin and pulse
	ttc_edge_if.det  edge_io
);
	logic prev_ff;
	logic fall_ff;

	// Two cycles to see 1 then 0; at most one count per two clocks
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			prev_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			prev_ff <= edge_io.pin;
			fall_ff <= prev_ff & ~edge_io.pin;
		end
	end

	assign edge_io.fall = fall_ff;
endmodule

// ===== dv/ttc_monitor.sv
// Checker on the timer unit ports: bus handshake, flags and pulses
`timescale 1ns/10ps
module ttc_monitor
	import ttc_pkg::*;
(
	// Clock and reset
	input wire logic       CLK,
	input wire logic       RSTN,
	// APB
	input wire logic       PSEL,
	input wire logic       PENABLE,
	input wire logic       PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic       PREADY,
	input wire logic       PSLVERR,
	// Service, flags and pulses
	input wire logic       ZERO_TIMER_SERVICE,
	input wire logic       FIRST_TIMER_SERVICE,
	input wire logic       ZERO_TIMER_OVERFLOW_FLAG,
	input wire logic       FIRST_TIMER_OVERFLOW_FLAG,
	input wire logic       FIRST_TIMER_OVERFLOW,
	input wire logic       THIRD_TIMER_OVERFLOW
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	wire logic ctl_wr = PSEL && PENABLE && PWRITE && PADDR == TTC_CTRL_OFF;
	wire logic bad_adr = PADDR[1:0] != 2'b00 || PADDR > TTC_ACK_OFF;

	a_ready_one_cycle: assert property (
		PSEL && !PENABLE |=> PREADY ##1 !PREADY)
		else $error("ready not one cycle after setup");
	a_ready_in_access: assert property (
		PREADY |-> PSEL && PENABLE)
		else $error("ready outside access phase");
	a_err_unmapped: assert property (
		PREADY && bad_adr |-> PSLVERR)
		else $error("no error for unmapped address");
	a_err_mapped: assert property (
		PREADY && !bad_adr |-> !PSLVERR)
		else $error("error on mapped address");
	a_flag0_clear: assert property (
		$fell(ZERO_TIMER_OVERFLOW_FLAG) |->
		$past(ZERO_TIMER_SERVICE) || $past(ctl_wr))
		else $error("timer zero flag dropped without cause");
	a_flag1_clear: assert property (
		$fell(FIRST_TIMER_OVERFLOW_FLAG) |->
		$past(FIRST_TIMER_SERVICE) || $past(ctl_wr))
		else $error("timer one flag dropped without cause");
	a_ovf1_single: assert property (
		FIRST_TIMER_OVERFLOW |=> !FIRST_TIMER_OVERFLOW)
		else $error("timer one overflow pulse too long");
	a_ovf2_single: assert property (
		THIRD_TIMER_OVERFLOW |=> !THIRD_TIMER_OVERFLOW)
		else $error("timer two overflow pulse too long");

	c_flag0: cover property ($rose(ZERO_TIMER_OVERFLOW_FLAG));
	c_flag1: cover property ($rose(FIRST_TIMER_OVERFLOW_FLAG));
	c_ovf2: cover property (THIRD_TIMER_OVERFLOW);
	c_slverr: cover property (PSLVERR);
endmodule

bind ttc_top ttc_monitor u_ttc_monitor (
	.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PREADY, .PSLVERR,
	.ZERO_TIMER_SERVICE, .FIRST_TIMER_SERVICE, .ZERO_TIMER_OVERFLOW_FLAG,
	.FIRST_TIMER_OVERFLOW_FLAG, .FIRST_TIMER_OVERFLOW, .THIRD_TIMER_OVERFLOW
);

// ===== dv/ttc_pin_model.sv
// Model of the external count, event and low-frequency clock pins
`timescale 1ns/10ps
module ttc_pin_model (
	// Clock
	input  wire logic clk,
	// Pins
	output logic      zero_timer_count_pin,
	output logic      first_timer_count_pin,
	output logic      third_timer_event_pin,
	output logic      low_freq_clock
);
	logic [3:0] pins;

	assign {low_freq_clock, third_timer_event_pin} = pins[3:2];
	assign {first_timer_count_pin, zero_timer_count_pin} = pins[1:0];
	// Count pins idle high, as with a pull-up
	initial pins = 4'h7;
	// Two edges per level, above the one-cycle minimum
	task automatic pulse(input int idx, input int n);
		repeat (n) begin
			@(posedge clk) pins[idx] <= 1'b0;
			@(posedge clk);
			@(posedge clk) pins[idx] <= 1'b1;
			@(posedge clk);
		end
	endtask
	task automatic level(input int idx, input logic v);
		@(posedge clk) pins[idx] <= v;
		@(posedge clk);
	endtask
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the triple timer/counter unit
`timescale 1ns/10ps
module testbench
	import ttc_pkg::*;
;
	logic        clk, rstn, psel, pen, pwr, zsvc, fsvc, slv;
	logic [7:0]  padr;
	logic [31:0] pwd, prd, rd;
	logic        prdy, perr, p0, p1, p2, lfc, f0, f1, ov1, ov2;
	int          error_cnt, compares, cyc;

	ttc_top u_ttc_top (
		.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
		.PREADY(prdy), .PSLVERR(perr), .ZERO_TIMER_COUNT_PIN(p0),
		.FIRST_TIMER_COUNT_PIN(p1), .THIRD_TIMER_EVENT_PIN(p2),
		.LOW_FREQ_CLOCK(lfc), .ZERO_TIMER_SERVICE(zsvc),
		.FIRST_TIMER_SERVICE(fsvc), .ZERO_TIMER_OVERFLOW_FLAG(f0),
		.FIRST_TIMER_OVERFLOW_FLAG(f1), .FIRST_TIMER_OVERFLOW(ov1),
		.THIRD_TIMER_OVERFLOW(ov2));
	ttc_pin_model u_ttc_pin_model (
		.clk(clk), .zero_timer_count_pin(p0), .first_timer_count_pin(p1),
		.third_timer_event_pin(p2), .low_freq_clock(lfc));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic end_sim();
		if (error_cnt == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// Idle edge after each transfer keeps drives one per time step
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (prdy !== 1'b1 && k < 16);
		rd = prd;
		slv = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
		if (k >= 16) begin
			chk("apb wait", 1'b0, 1'b1);
			end_sim();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdx(input string n, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, rd, e);
	endtask
	task automatic waitfor(input int i);
		logic [3:0] s;
		for (cyc = 0; cyc < 64; cyc++) begin
			@(posedge clk);
			s = {ov2, ov1, f1, f0};
			if (s[i] === 1'b1)
				break;
		end
		if (cyc >= 64) begin
			chk("flag wait", 1'b0, 1'b1);
			end_sim();
		end
	endtask
	task automatic svc(input int i);
		if (i == 0)
			zsvc <= 1'b1;
		else
			fsvc <= 1'b1;
		@(posedge clk);
		zsvc <= 1'b0;
		fsvc <= 1'b0;
		@(posedge clk);
		@(posedge clk);
	endtask
	task automatic t_regs();
		rdx("ctrl rst", TTC_CTRL_OFF, 32'h0000_0000);
		rdx("tm0 rst", TTC_TM0_OFF, 32'h0000_0000);
		wr(TTC_MODE_OFF, 32'h0000_0045);
		rdx("mode rw", TTC_MODE_OFF, 32'h0000_0045);
		rdx("unmapped", 8'h30, 32'h0000_0000);
		chk("slverr", slv, 32'h0000_0001);
	endtask
	task automatic t_tm0();
		wr(TTC_MODE_OFF, 32'h0000_0004);
		wr(TTC_TM0_OFF, 32'h0000_FFFF);
		wr(TTC_CTRL_OFF, 32'h0000_0010);
		u_ttc_pin_model.pulse(0, 1);
		waitfor(0);
		rdx("m0 wrap", TTC_TM0_OFF, 32'h0000_00E0);
		svc(0);
		chk("svc clear", f0, 32'h0000_0000);
		wr(TTC_CTRL_OFF, 32'h0000_0000);
		u_ttc_pin_model.pulse(0, 2);
		rdx("run off", TTC_TM0_OFF, 32'h0000_00E0);
		wr(TTC_MODE_OFF, 32'h0000_0001);
		wr(TTC_TM0_OFF, 32'h0000_FFFE);
		wr(TTC_CTRL_OFF, 32'h0000_0010);
		waitfor(0);
		// Two ticks 12 apart, first one at any prescaler phase
		chk("tick span", cyc >= 12 && cyc <= 23, 1'b1);
		rdx("m1 wrap", TTC_TM0_OFF, 32'h0000_0000);
	endtask
	task automatic t_tm1();
		wr(TTC_MODE_OFF, 32'h0000_0060);
		wr(TTC_TM1_OFF, 32'h0000_F0FE);
		wr(TTC_CTRL_OFF, 32'h0000_0040);
		u_ttc_pin_model.pulse(1, 2);
		waitfor(1);
		rdx("m2 reload", TTC_TM1_OFF, 32'h0000_F0F0);
		svc(1);
		wr(TTC_MODE_OFF, 32'h0000_0070);
		wr(TTC_TM1_OFF, 32'h0000_1234);
		u_ttc_pin_model.pulse(1, 3);
		rdx("m3 hold", TTC_TM1_OFF, 32'h0000_1234);
	endtask
	task automatic t_split();
		wr(TTC_CTRL_OFF, 32'h0000_0000);
		wr(TTC_MODE_OFF, 32'h0000_0007);
		wr(TTC_TM0_OFF, 32'h0000_00FF);
		wr(TTC_CTRL_OFF, 32'h0000_0010);
		u_ttc_pin_model.pulse(0, 1);
		rdx("split low", TTC_TM0_OFF, 32'h0000_0000);
		chk("split flags", {f1, f0}, 32'h0000_0001);
		wr(TTC_CTRL_OFF, 32'h0000_0050);
		repeat (30) @(posedge clk);
		apb(1'b0, TTC_TM0_OFF, 32'h0000_0000);
		chk("split high", rd[15:8] inside {8'h02, 8'h03}, 1'b1);
		// Timer one keeps wrapping as a baud source, flag stays quiet
		wr(TTC_MODE_OFF, 32'h0000_0027);
		wr(TTC_TM1_OFF, 32'h0000_00FE);
		waitfor(2);
		chk("split no flag", f1, 32'h0000_0000);
	endtask
	task automatic t_t2clk();
		for (int ps = 0; ps < 2; ps++) begin
			wr(TTC_TM2_OFF, 32'h0000_0000);
			wr(TTC_T2CTL_OFF, {24'h00_0000, ps[0], 7'h01});
			repeat (120) @(posedge clk);
			wr(TTC_T2CTL_OFF, 32'h0000_0000);
			apb(1'b0, TTC_TM2_OFF, 32'h0000_0000);
			chk("tm2 rate", rd inside {[10 / (ps + 1):11 / (ps + 1) + ps]},
				1'b1);
			repeat (30) @(posedge clk);
			rdx("tm2 stop", TTC_TM2_OFF, rd);
		end
	endtask
	task automatic t_t2evt();
		wr(TTC_TM2_OFF, 32'h0000_0000);
		wr(TTC_T2CTL_OFF, 32'h0000_0002);
		u_ttc_pin_model.pulse(2, 5);
		rdx("tm2 events", TTC_TM2_OFF, 32'h0000_0005);
		wr(TTC_T2CTL_OFF, 32'h0000_0000);
		u_ttc_pin_model.level(2, 1'b0);
		wr(TTC_T2CTL_OFF, 32'h0000_0003);
		repeat (60) @(posedge clk);
		rdx("tm2 gated", TTC_TM2_OFF, 32'h0000_0005);
		// Gate open for 61 edges: five or six more ticks
		u_ttc_pin_model.level(2, 1'b1);
		repeat (60) @(posedge clk);
		apb(1'b0, TTC_TM2_OFF, 32'h0000_0000);
		chk("tm2 gate open", rd inside {[10:11]}, 1'b1);
		wr(TTC_T2CTL_OFF, 32'h0000_0000);
	endtask
	task automatic t_t2rld();
		wr(TTC_RLD_OFF, 32'h0000_FFF0);
		wr(TTC_TM2_OFF, 32'h0000_FFFE);
		wr(TTC_T2CTL_OFF, 32'h0000_0012);
		u_ttc_pin_model.pulse(2, 1);
		// Second fall by hand so the one-cycle overflow pulse is watched
		u_ttc_pin_model.level(2, 1'b0);
		waitfor(3);
		u_ttc_pin_model.level(2, 1'b1);
		rdx("tm2 ovf load", TTC_TM2_OFF, 32'h0000_FFF0);
		wr(TTC_T2CTL_OFF, 32'h0000_0002);
		wr(TTC_TM2_OFF, 32'h0000_FFFF);
		u_ttc_pin_model.pulse(2, 1);
		rdx("tm2 no load", TTC_TM2_OFF, 32'h0000_0000);
		wr(TTC_T2CTL_OFF, 32'h0000_0000);
		wr(TTC_TM2_OFF, 32'h0000_0001);
		wr(TTC_RLD_OFF, 32'h0000_ABCD);
		u_ttc_pin_model.pulse(3, 2);
		rdx("tm2 trig off", TTC_TM2_OFF, 32'h0000_0001);
		wr(TTC_T2CTL_OFF, 32'h0000_0018);
		u_ttc_pin_model.pulse(3, 2);
		repeat (4) @(posedge clk);
		rdx("tm2 trig load", TTC_TM2_OFF, 32'h0000_ABCD);
		wr(TTC_ACK_OFF, 32'h0000_0002);
		rdx("capture", TTC_CAP_OFF + 8'h08, 32'h0000_ABCD);
	endtask

	initial begin
		rstn = 1'b0;
		{psel, pen, pwr, zsvc, fsvc} = 5'h00;
		padr = 8'h00;
		pwd = 32'h0000_0000;
		error_cnt = 0;
		compares = 0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_tm0();
		t_tm1();
		t_split();
		t_t2clk();
		t_t2evt();
		t_t2rld();
		end_sim();
	end
endmodule
